// File: rmiirc_defines.svh
/*
 * Offsets, field positions, reset values, function codes and timing counts
 * of the reference clock routing block.
 * Assumes a 125 MHz register clock and 32-bit AXI4-Lite byte addressing.
 */
`ifndef RMIIRC_DEFINES_SVH
`define RMIIRC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RMIIRC_OFF_ROUTE 8'h00
`define RMIIRC_OFF_PREF_PAD 8'h04
`define RMIIRC_OFF_ALT_PAD 8'h08
`define RMIIRC_OFF_PLL 8'h0c
`define RMIIRC_OFF_STATUS 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define RMIIRC_ROUTE_SRC_BIT 0
`define RMIIRC_ROUTE_SEL_BIT 1
`define RMIIRC_PAD_FUNC_LSB 0
`define RMIIRC_PAD_FORCE_BIT 4
`define RMIIRC_PLL_FREQ_LSB 0

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RMIIRC_RST_SRC 1'h0
`define RMIIRC_RST_SEL 1'h0
`define RMIIRC_RST_FUNC 3'h0
`define RMIIRC_RST_FORCE 1'h0
`define RMIIRC_RST_PLL_FREQ 2'h0
`define RMIIRC_FUNC_PREF 3'h2
`define RMIIRC_FUNC_ALT 3'h7
`define RMIIRC_PLL_FREQ_50MHZ 2'h1
`define RMIIRC_RESP_OKAY 2'h0
`define RMIIRC_RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define RMIIRC_ACLK_PERIOD_NS 8
`define RMIIRC_ALIVE_TIMEOUT_NS 2000
`define RMIIRC_ALIVE_TIMEOUT_CYC ((`RMIIRC_ALIVE_TIMEOUT_NS + `RMIIRC_ACLK_PERIOD_NS - 1) / `RMIIRC_ACLK_PERIOD_NS)

`endif

// File: rmiirc_pkg.sv
/*
 * Types of the reference clock routing block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rmiirc_pkg;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RDATA = 3'b100
    } rmiirc_bus_e;

    typedef struct packed {
        logic src;
        logic sel;
    } rmiirc_route_s;

    typedef struct packed {
        logic [2:0] func;
        logic force_in;
    } rmiirc_pad_s;

    typedef struct packed {
        logic use_pref;
        logic pref_ok;
        logic alt_ok;
        logic path_ok;
        logic drive_out;
    } rmiirc_path_s;

endpackage

// File: rmiirc_link.sv
/*
 * Link side activity monitor: runs on the selected reference clock and
 * tells the register clock domain whether that clock is toggling.
 * Assumes link_clk may stop at any time; the register side times it out.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rmiirc_defines.svh"

module rmiirc_link (
    input wire logic link_clk,
    input wire logic aclk,
    input wire logic aresetn,
    output logic alive
);

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic [2:0] div;
        logic tog;
    } rmiirc_lnk_s;

    typedef struct packed {
        logic tog_meta;
        logic tog_s1;
        logic tog_s2;
        logic [8:0] timer;
        logic alive;
    } rmiirc_mon_s;

    localparam logic [8:0] TIMEOUT = 9'(`RMIIRC_ALIVE_TIMEOUT_CYC);

    rmiirc_lnk_s lnk, next_lnk;
    rmiirc_mon_s mon, next_mon;

    // ****************************************************************
    // Link domain
    // ****************************************************************
    // Reset reaches this domain through two flops; a stopped clock simply
    // leaves the toggle frozen, which the register side detects.
    always_comb begin
        next_lnk = lnk;
        next_lnk.rst_meta = aresetn;
        next_lnk.rst_sync = lnk.rst_meta;
        // The link clock often starts only after reset has gone, so the
        // divider stays clear until the reset chain has filled and reads high.
        if (lnk.rst_sync) begin
            next_lnk.div = lnk.div + 3'h1;
            if (lnk.div == 3'h7) begin
                next_lnk.tog = ~lnk.tog;
            end
        end else begin
            next_lnk.div = 3'h0;
            next_lnk.tog = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        lnk <= next_lnk;
    end

    // ****************************************************************
    // Register clock domain
    // ****************************************************************
    always_comb begin
        next_mon = mon;
        next_mon.tog_meta = lnk.tog;
        next_mon.tog_s1 = mon.tog_meta;
        next_mon.tog_s2 = mon.tog_s1;
        if (mon.tog_s1 != mon.tog_s2) begin
            next_mon.timer = TIMEOUT;
            next_mon.alive = 1'b1;
        end else if (mon.timer != 9'h0) begin
            next_mon.timer = mon.timer - 9'h1;
        end else begin
            next_mon.alive = 1'b0;
        end
        if (!aresetn) begin
            next_mon = '0;
        end
    end

    always_ff @(posedge aclk) begin
        mon <= next_mon;
    end

    assign alive = mon.alive;

endmodule

`default_nettype wire

// File: rmiirc_top.sv
/*
 * Reference clock routing for a reduced-interface Ethernet MAC: source
 * select, pad input select, pad function codes, force-input bits and the
 * PLL frequency field, behind an AXI4-Lite slave.
 * Assumes mac_idle comes from MAC logic on aclk, pll_ref_clk is the
 * internal Ethernet PLL output, and the bench resolves each pad wire from
 * its output enable.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rmiirc_defines.svh"

module rmiirc_top #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mac_idle,
    input wire logic pll_ref_clk,
    input wire logic pref_pad_i,
    output logic pref_pad_o,
    output logic pref_pad_oe,
    output logic pref_pad_force_in,
    input wire logic alt_pad_i,
    output logic alt_pad_o,
    output logic alt_pad_oe,
    output logic alt_pad_force_in,
    output logic [1:0] pll_freq_sel,
    output logic mac_ref_clk
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        rmiirc_pkg::rmiirc_bus_e bus;
        logic aw_have;
        logic w_have;
        logic [7:0] waddr;
        logic [7:0] wbyte;
        logic wlane0;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Req holds what software wrote; applied is what drives the pads
        rmiirc_pkg::rmiirc_route_s req;
        rmiirc_pkg::rmiirc_route_s applied;
        rmiirc_pkg::rmiirc_pad_s pref;
        rmiirc_pkg::rmiirc_pad_s alt;
        logic [1:0] pll_freq;
    } rmiirc_state_s;

    rmiirc_state_s st, next_st;
    rmiirc_pkg::rmiirc_path_s path;
    logic clk_alive;
    logic wr_fire;
    logic rd_fire;
    logic pending;

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        addr_hit = (addr[7:2] == off[7:2]);
    endfunction

    // ****************************************************************
    // Pad register layout, shared by both pads
    // ****************************************************************
    function automatic rmiirc_pkg::rmiirc_pad_s pad_from_byte(input logic [7:0] b);
        rmiirc_pkg::rmiirc_pad_s p;
        p.func = b[`RMIIRC_PAD_FUNC_LSB +: 3];
        p.force_in = b[`RMIIRC_PAD_FORCE_BIT];
        pad_from_byte = p;
    endfunction

    function automatic logic [31:0] pad_to_word(input rmiirc_pkg::rmiirc_pad_s p);
        pad_to_word = 32'h0;
        pad_to_word[`RMIIRC_PAD_FUNC_LSB +: 3] = p.func;
        pad_to_word[`RMIIRC_PAD_FORCE_BIT] = p.force_in;
    endfunction

    // ****************************************************************
    // Pad selection and routing
    // ****************************************************************
    always_comb begin
        // The input-select polarity is fixed by the device variant.
        if (SMALL_VARIANT) begin
            path.use_pref = ~st.applied.sel;
        end else begin
            path.use_pref = st.applied.sel;
        end
        path.pref_ok = (st.pref.func == `RMIIRC_FUNC_PREF);
        path.alt_ok = (st.alt.func == `RMIIRC_FUNC_ALT);
        // A wrong function code opens the path rather than pass a stray level
        path.path_ok = path.use_pref ? path.pref_ok : path.alt_ok;
        path.drive_out = st.applied.src & path.path_ok;
    end

    // Clock signals pass as plain gates; a flop here would halve them.
    assign pref_pad_oe = path.drive_out & path.use_pref;
    assign alt_pad_oe = path.drive_out & ~path.use_pref;
    assign pref_pad_o = pref_pad_oe & pll_ref_clk;
    assign alt_pad_o = alt_pad_oe & pll_ref_clk;

    // The MAC takes its clock back from the pad while path_ok is set, whether the pad is
    // driven from outside or by our own loopback; the force bit is only a
    // hint for the input buffer and is not needed for the path.
    always_comb begin
        if (!path.path_ok) begin
            mac_ref_clk = 1'b0;
        end else if (path.use_pref) begin
            mac_ref_clk = pref_pad_i;
        end else begin
            mac_ref_clk = alt_pad_i;
        end
    end

    assign pref_pad_force_in = st.pref.force_in;
    assign alt_pad_force_in = st.alt.force_in;
    assign pll_freq_sel = st.pll_freq;

    rmiirc_link u_link (
        .link_clk(mac_ref_clk),
        .aclk(aclk),
        .aresetn(aresetn),
        .alive(clk_alive)
    );

    // ****************************************************************
    // AXI4-Lite handshakes
    // ****************************************************************
    // Writes win over reads; a read waits while half a write is held.
    // A write lands the edge after both halves are held; bvalid rises at that same edge.
    assign s_axi_awready = (st.bus == rmiirc_pkg::BUS_IDLE) & ~st.aw_have;
    assign s_axi_wready = (st.bus == rmiirc_pkg::BUS_IDLE) & ~st.w_have;
    assign s_axi_arready = (st.bus == rmiirc_pkg::BUS_IDLE) & ~st.aw_have & ~st.w_have
        & ~s_axi_awvalid & ~s_axi_wvalid;
    assign s_axi_bvalid = (st.bus == rmiirc_pkg::BUS_WRESP);
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = (st.bus == rmiirc_pkg::BUS_RDATA);
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    assign wr_fire = st.aw_have & st.w_have;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    // Software polls pending to learn when a route change has landed.
    assign pending = (st.req != st.applied);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        case (st.bus)
            rmiirc_pkg::BUS_IDLE: begin
                if (s_axi_awvalid & s_axi_awready) begin
                    next_st.aw_have = 1'b1;
                    next_st.waddr = s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    next_st.w_have = 1'b1;
                    next_st.wbyte = s_axi_wdata[7:0];
                    next_st.wlane0 = s_axi_wstrb[0];
                end
                if (wr_fire) begin
                    next_st.aw_have = 1'b0;
                    next_st.w_have = 1'b0;
                    next_st.bresp = `RMIIRC_RESP_OKAY;
                    next_st.bus = rmiirc_pkg::BUS_WRESP;
                    // All fields sit in byte lane 0.
                    if (addr_hit(st.waddr, `RMIIRC_OFF_ROUTE)) begin
                        if (st.wlane0) begin
                            next_st.req.src = st.wbyte[`RMIIRC_ROUTE_SRC_BIT];
                            next_st.req.sel = st.wbyte[`RMIIRC_ROUTE_SEL_BIT];
                        end
                    end else if (addr_hit(st.waddr, `RMIIRC_OFF_PREF_PAD)) begin
                        if (st.wlane0) begin
                            next_st.pref = pad_from_byte(st.wbyte);
                        end
                    end else if (addr_hit(st.waddr, `RMIIRC_OFF_ALT_PAD)) begin
                        if (st.wlane0) begin
                            next_st.alt = pad_from_byte(st.wbyte);
                        end
                    end else if (addr_hit(st.waddr, `RMIIRC_OFF_PLL)) begin
                        if (st.wlane0) begin
                            next_st.pll_freq = st.wbyte[`RMIIRC_PLL_FREQ_LSB +: 2];
                        end
                    end else if (addr_hit(st.waddr, `RMIIRC_OFF_STATUS)) begin
                        next_st.bresp = `RMIIRC_RESP_OKAY;
                    end else begin
                        next_st.bresp = `RMIIRC_RESP_SLVERR;
                    end
                end else if (rd_fire) begin
                    // Registered, so rdata stands unchanged until rready
                    next_st.rdata = 32'h0;
                    next_st.rresp = `RMIIRC_RESP_OKAY;
                    next_st.bus = rmiirc_pkg::BUS_RDATA;
                    if (addr_hit(s_axi_araddr, `RMIIRC_OFF_ROUTE)) begin
                        next_st.rdata[`RMIIRC_ROUTE_SRC_BIT] = st.req.src;
                        next_st.rdata[`RMIIRC_ROUTE_SEL_BIT] = st.req.sel;
                    end else if (addr_hit(s_axi_araddr, `RMIIRC_OFF_PREF_PAD)) begin
                        next_st.rdata = pad_to_word(st.pref);
                    end else if (addr_hit(s_axi_araddr, `RMIIRC_OFF_ALT_PAD)) begin
                        next_st.rdata = pad_to_word(st.alt);
                    end else if (addr_hit(s_axi_araddr, `RMIIRC_OFF_PLL)) begin
                        next_st.rdata[`RMIIRC_PLL_FREQ_LSB +: 2] = st.pll_freq;
                    end else if (addr_hit(s_axi_araddr, `RMIIRC_OFF_STATUS)) begin
                        next_st.rdata[0] = st.applied.src;
                        next_st.rdata[1] = st.applied.sel;
                        next_st.rdata[2] = pending;
                        next_st.rdata[3] = path.path_ok;
                        next_st.rdata[4] = clk_alive;
                        next_st.rdata[5] = (st.pll_freq == `RMIIRC_PLL_FREQ_50MHZ);
                        next_st.rdata[6] = path.use_pref;
                    end else begin
                        next_st.rresp = `RMIIRC_RESP_SLVERR;
                    end
                end
            end
            rmiirc_pkg::BUS_WRESP: begin
                if (s_axi_bready) begin
                    next_st.bus = rmiirc_pkg::BUS_IDLE;
                end
            end
            rmiirc_pkg::BUS_RDATA: begin
                if (s_axi_rready) begin
                    next_st.bus = rmiirc_pkg::BUS_IDLE;
                end
            end
            default: begin
                next_st.bus = rmiirc_pkg::BUS_IDLE;
            end
        endcase

        // A change of source or pad while the MAC runs could hand it a
        // runt pulse, so the request waits until the MAC reports idle.
        if (mac_idle) begin
            next_st.applied = st.req;
        end

        // Every field returns to its default; the select bit must read zero.
        if (!aresetn) begin
            next_st = '0;
            next_st.bus = rmiirc_pkg::BUS_IDLE;
            next_st.bresp = `RMIIRC_RESP_OKAY;
            next_st.rresp = `RMIIRC_RESP_OKAY;
            next_st.req.src = `RMIIRC_RST_SRC;
            next_st.req.sel = `RMIIRC_RST_SEL;
            next_st.applied.src = `RMIIRC_RST_SRC;
            next_st.applied.sel = `RMIIRC_RST_SEL;
            next_st.pref.func = `RMIIRC_RST_FUNC;
            next_st.pref.force_in = `RMIIRC_RST_FORCE;
            next_st.alt.func = `RMIIRC_RST_FUNC;
            next_st.alt.force_in = `RMIIRC_RST_FORCE;
            next_st.pll_freq = `RMIIRC_RST_PLL_FREQ;
        end
    end

    always_ff @(posedge aclk) begin
        st <= next_st;
    end

endmodule

`default_nettype wire

// File: rmiirc_assertions.sv
/*
 * Port checker for rmiirc_top: pad drive, clock path, reset state and
 * register effects on the routing outputs.
 * Assumes it is bound to rmiirc_top and that writes use byte offsets.
 */
`timescale 1ns/1ps
`default_nettype none

module rmiirc_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic mac_idle,
    input wire logic pll_ref_clk,
    input wire logic pref_pad_i,
    input wire logic pref_pad_o,
    input wire logic pref_pad_oe,
    input wire logic pref_pad_force_in,
    input wire logic alt_pad_i,
    input wire logic alt_pad_o,
    input wire logic alt_pad_oe,
    input wire logic [1:0] pll_freq_sel,
    input wire logic mac_ref_clk
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Both channels taken at one edge; the bench always offers them together
    logic wr;
    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];

    // ****************************************************************
    // Routing
    // ****************************************************************
    AST_ONE_PAD: assert property (!(pref_pad_oe && alt_pad_oe))
        else $error("both pads driven at once");
    AST_PAD_PLL: assert property ((pref_pad_oe || alt_pad_oe) |-> (pref_pad_o | alt_pad_o) == pll_ref_clk)
        else $error("driven pad does not carry the PLL clock");
    AST_MAC_PAD: assert property (mac_ref_clk |-> (pref_pad_i || alt_pad_i))
        else $error("MAC clock high with both pads low");
    AST_SRC_CLEAR: assert property (wr && s_axi_awaddr == 8'h00 && !s_axi_wdata[0] ##2 mac_idle |=> !pref_pad_oe && !alt_pad_oe)
        else $error("pad still driven with source clear");
    AST_HOLD: assert property (!$past(mac_idle) && !s_axi_bvalid |-> $stable(pref_pad_oe) && $stable(alt_pad_oe))
        else $error("routing changed while MAC busy");

    // ****************************************************************
    // Reset and register effects
    // ****************************************************************
    AST_RESET: assert property ($rose(aresetn) |-> !pref_pad_oe && !alt_pad_oe && pll_freq_sel == 2'h0 && !pref_pad_force_in)
        else $error("outputs not at reset state");
    AST_PLL_WR: assert property (wr && s_axi_awaddr == 8'h0c |-> ##2 pll_freq_sel == $past(s_axi_wdata[1:0], 2))
        else $error("PLL field not as written");
    AST_FORCE_WR: assert property (wr && s_axi_awaddr == 8'h04 |-> ##2 pref_pad_force_in == $past(s_axi_wdata[4], 2))
        else $error("force bit not as written");
    AST_PREF_FUNC: assert property (wr && s_axi_awaddr == 8'h04 && s_axi_wdata[2:0] != 3'h2 |-> ##2 !pref_pad_oe)
        else $error("preferred pad driven with wrong function");
    AST_ALT_FUNC: assert property (wr && s_axi_awaddr == 8'h08 && s_axi_wdata[2:0] != 3'h7 |-> ##2 !alt_pad_oe)
        else $error("alternate pad driven with wrong function");
endmodule

bind rmiirc_top rmiirc_assertions i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .mac_idle(mac_idle), .pll_ref_clk(pll_ref_clk), .pref_pad_i(pref_pad_i),
    .pref_pad_o(pref_pad_o), .pref_pad_oe(pref_pad_oe), .pref_pad_force_in(pref_pad_force_in),
    .alt_pad_i(alt_pad_i), .alt_pad_o(alt_pad_o), .alt_pad_oe(alt_pad_oe), .pll_freq_sel(pll_freq_sel),
    .mac_ref_clk(mac_ref_clk));

`default_nettype wire

// File: rmiirc_phy_model.sv
/*
 * Far side model: a PHY or oscillator supplying the reference clock.
 * Assumes the bench enables it only while the block's source bit is clear.
 */
`timescale 1ns/1ps
`default_nettype none

module rmiirc_phy_model #(
    parameter int HALF_NS = 40
) (
    input wire logic drive_en,
    output logic clk_o,
    output logic clk_oe
);
    // Free running, phase unrelated to the register clock
    initial begin
        clk_o = 1'b0;
        #13;
        forever #(HALF_NS) clk_o = ~clk_o;
    end

    assign clk_oe = drive_en;
endmodule

`default_nettype wire

// File: rmiirc_testbench.sv
/*
 * Testbench for rmiirc_top: register access, PLL loop-out, pad input,
 * idle-gated route change and the alternate pad.
 * Assumes the design's byte offsets; a smaller-variant twin shares the bus.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic mac_idle = 1'b1;
    logic pll_clk = 1'b0;
    logic phy_en = 1'b0;
    logic flt = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pref_o, pref_oe, pref_f, alt_o, alt_oe, alt_f, mac_clk;
    logic pref_w, alt_w, phy_clk, phy_oe;
    logic s_pref_o, s_pref_oe, s_alt_o, s_alt_oe;
    logic [1:0] bresp, rresp, pll_sel;
    logic [31:0] rdata;
    int fail_count = 0;
    int n_compared = 0;
    int edges = 0;

    always #4 aclk = ~aclk;
    always #7 flt = ~flt;
    initial begin
        #1;
        forever #10 pll_clk = ~pll_clk;
    end
    always @(posedge mac_clk) edges++;

    // Undriven pads float: a changing pattern, never the last driven level
    assign pref_w = pref_oe ? pref_o : (phy_oe ? phy_clk : flt);
    assign alt_w = alt_oe ? alt_o : flt;

    rmiirc_phy_model i_phy (.drive_en(phy_en), .clk_o(phy_clk), .clk_oe(phy_oe));

    rmiirc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mac_idle(mac_idle), .pll_ref_clk(pll_clk), .pref_pad_i(pref_w),
        .pref_pad_o(pref_o), .pref_pad_oe(pref_oe), .pref_pad_force_in(pref_f), .alt_pad_i(alt_w),
        .alt_pad_o(alt_o), .alt_pad_oe(alt_oe), .alt_pad_force_in(alt_f), .pll_freq_sel(pll_sel),
        .mac_ref_clk(mac_clk));

    // Smaller variant on the same bus: only its reversed select polarity is checked
    rmiirc_top #(.SMALL_VARIANT(1'b1)) i_dut_small (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready), .mac_idle(mac_idle), .pll_ref_clk(pll_clk),
        .pref_pad_i(s_pref_o), .pref_pad_o(s_pref_o), .pref_pad_oe(s_pref_oe), .pref_pad_force_in(),
        .alt_pad_i(s_alt_o), .alt_pad_o(s_alt_o), .alt_pad_oe(s_alt_oe), .alt_pad_force_in(), .pll_freq_sel(),
        .mac_ref_clk());

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One AXI4-Lite transfer; handshakes judged from values settled before the edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, dn;
        logic [31:0] rd;
        logic [1:0] rs;
        int i;
        dn = 1'b0;
        @(posedge aclk);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        for (i = 0; i < 100 && !dn; i++) begin
            @(negedge aclk);
            ah = (awvalid && awready) || (arvalid && arready);
            wh = wvalid && wready;
            dn = w ? (bvalid && bready) : (rvalid && rready);
            rd = rdata;
            rs = w ? bresp : rresp;
            @(posedge aclk);
            if (ah) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (wh)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        if (!dn) begin
            fail_count++;
            end_of_test();
        end
        check({30'h0, rs}, {30'h0, er});
        if (!w)
            check(rd, d);
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 5; k++)
            xfer(1'b0, 8'(k * 4), 32'h0, 2'h0);
        xfer(1'b0, 8'h14, 32'h0, 2'h2);
        xfer(1'b1, 8'h14, 32'hff, 2'h2);
        $display("test reset values done");

        xfer(1'b1, 8'h0c, 32'h1, 2'h0);
        check(pll_sel, 2'h1);
        xfer(1'b1, 8'h04, 32'h12, 2'h0);
        check(pref_f, 1'b1);
        xfer(1'b1, 8'h00, 32'h3, 2'h0);
        repeat (3) @(posedge aclk);
        check({pref_oe, alt_oe}, 2'b10);
        check({s_pref_oe, s_alt_oe}, 2'b00);
        repeat (6) begin
            @(negedge aclk);
            check(mac_clk, pll_clk);
        end
        repeat (40) @(posedge aclk);
        xfer(1'b0, 8'h10, 32'h7b, 2'h0);
        $display("test internal clock done");

        mac_idle <= 1'b0;
        xfer(1'b1, 8'h00, 32'h2, 2'h0);
        repeat (5) @(posedge aclk);
        check(pref_oe, 1'b1);
        xfer(1'b0, 8'h10, 32'h7f, 2'h0);
        mac_idle <= 1'b1;
        repeat (3) @(posedge aclk);
        check({pref_oe, alt_oe}, 2'b00);
        phy_en <= 1'b1;
        repeat (150) @(posedge aclk);
        edges = 0;
        repeat (100) @(posedge aclk);
        check(edges >= 9 && edges <= 11, 1'b1);
        xfer(1'b0, 8'h10, 32'h7a, 2'h0);
        $display("test external clock done");

        phy_en <= 1'b0;
        xfer(1'b1, 8'h00, 32'h0, 2'h0);
        xfer(1'b1, 8'h00, 32'h1, 2'h0);
        repeat (3) @(posedge aclk);
        check({pref_oe, alt_oe}, 2'b00);
        check({s_pref_oe, s_alt_oe}, 2'b10);
        xfer(1'b1, 8'h08, 32'h17, 2'h0);
        check({pref_oe, alt_oe, alt_f}, 3'b011);
        @(negedge aclk);
        check(mac_clk, pll_clk);
        xfer(1'b0, 8'h00, 32'h1, 2'h0);
        xfer(1'b0, 8'h08, 32'h17, 2'h0);
        xfer(1'b1, 8'h08, 32'h3, 2'h0);
        check(alt_oe, 1'b0);
        $display("test alternate pad done");
        end_of_test();
    end
endmodule

`default_nettype wire
